/* bench/mspc_board_model.sv */
// board straps and debug host standing outside the configuration block
`timescale 1ns/1ps
`default_nettype none
module mspc_board_model (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic [2:0] pat,
  input  wire logic       rom,
  input  wire logic       osc,
  input  wire logic       cmd,
  output var  logic       modeStrapHigh,
  output var  logic       modeStrapMid,
  output var  logic       modeStrapLow,
  output var  logic       flashMapStrap,
  output var  logic       oscillatorTypeStrap,
  output var  logic       debugActivateCmd
);
  always @(posedge core_clk)
  begin
    // straps move only inside reset, peripheral pattern never strapped
    if (srst && pat != 3'h6)
    begin
      {modeStrapHigh, modeStrapMid, modeStrapLow} <= pat;
      flashMapStrap <= rom;
      oscillatorTypeStrap <= osc;
    end
    debugActivateCmd <= cmd;
  end
endmodule // mspc_board_model
`default_nettype wire

/* bench/mspc_config_assertions.sv */
// port checker for the configuration block
`timescale 1ns/1ps
`default_nettype none
module mspc_chk (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       flashMapStrap,
  input wire logic       oscillatorTypeStrap,
  input wire logic       debugActivateCmd,
  input wire logic       avsRead,
  input wire logic       avsWrite,
  input wire logic       avsWaitRequest,
  input wire logic [2:0] modeBits,
  input wire logic       flashVisible,
  input wire logic       flashInMap,
  input wire logic       colpittsSel,
  input wire logic       debugActive,
  input wire logic       debugBlocked,
  input wire logic       secured
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_SSC: assert property ($fell(srst) ##3 modeBits == 3'h0 |-> debugActive && flashVisible)
    else $error("special single chip capture wrong");
  AST_IDLE: assert property ($fell(srst) ##0 !debugActivateCmd [*4] ##0 modeBits != 3'h0
    |-> !debugActive) else $error("debug active without command");
  AST_EMU: assert property ($fell(srst) ##3 (modeBits == 3'h1 || modeBits == 3'h3)
    |-> flashVisible == !flashMapStrap) else $error("emulation flash visible wrong");
  AST_STW: assert property ($fell(srst) ##3 modeBits == 3'h2 |-> !flashVisible)
    else $error("test mode flash visible set");
  AST_NSC: assert property ($fell(srst) ##3 modeBits == 3'h4 |-> flashVisible)
    else $error("single chip flash visible clear");
  AST_NXP: assert property ($fell(srst) ##3 (modeBits == 3'h5 || modeBits == 3'h7)
    |-> flashVisible == flashMapStrap) else $error("expanded flash visible wrong");
  AST_OSC: assert property ($fell(srst) ##3 1'b1 |-> colpittsSel == oscillatorTypeStrap)
    else $error("oscillator select wrong");
  AST_MAP: assert property (!flashVisible && !$past(flashVisible) |-> !flashInMap)
    else $error("hidden flash in map");
  AST_SECNSC: assert property ($fell(srst) ##4 secured && modeBits == 3'h4
    |-> debugBlocked && flashInMap) else $error("secured single chip wrong");
  AST_SECEXP: assert property ($fell(srst) ##4 secured && modeBits[0]
    |-> debugBlocked && !flashInMap) else $error("secured expanded wrong");
  AST_RESEC: assert property ($fell(srst) |-> secured)
    else $error("not secured out of reset");
  AST_ANS: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("bus answer late");
  AST_ONE: assert property (!avsWaitRequest |=> avsWaitRequest)
    else $error("waitrequest low too long");
endmodule // mspc_chk
bind mspc_config mspc_chk i_mspc_chk (.*);
`default_nettype wire

/* bench/mspc_tb.sv */
// self-checking bench for the configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk, srst, flashErased, wakeInterrupt, stopInstr, waitInstr, avsRead, avsWrite;
  logic [1:0] nvSecBits;
  logic [3:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData, rd;
  logic avsWaitRequest, flashVisible, flashInMap, colpittsSel, debugActive, debugBlocked;
  logic secured, secProgramOk, oscEnable, coreClkEn, periphClkEn, tickWdogEn, cpuHalt;
  logic modeStrapHigh, modeStrapMid, modeStrapLow, flashMapStrap, oscillatorTypeStrap;
  logic debugActivateCmd, rom, osc, cmd;
  logic [2:0] pat, modeBits;
  int bad_count, num_checks, cyc;
  // rows: pattern, flash-map strap, expected flash visible
  logic [4:0] rows [8] = '{5'h03, 5'h05, 5'h06, 5'h0a, 5'h0e, 5'h11, 5'h17, 5'h1c};
  mspc_config #(.VERIFY_CYCLES(2)) i_mspc_config (.*);
  mspc_board_model i_mspc_board_model (.*);
  ////////////////////////////////////////
  initial
  begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  task results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      results;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task rstRun;
    srst <= 1;
    repeat (12) @(posedge core_clk);
    srst <= 0;
    repeat (6) @(posedge core_clk);
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avsAddress <= a;
    avsWriteData <= d;
    avsRead <= !w;
    avsWrite <= w;
    do @(posedge core_clk); while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    avsRead <= 0;
    avsWrite <= 0;
  endtask
  task lowPower(input logic s, input logic [1:0] m);
    bus(1, 4'h3, {30'h0, m});
    stopInstr <= s;
    waitInstr <= !s;
    @(posedge core_clk);
    stopInstr <= 0;
    waitInstr <= 0;
    repeat (5) @(posedge core_clk);
  endtask
  task wake;
    wakeInterrupt <= 1;
    repeat (6) @(posedge core_clk);
    wakeInterrupt <= 0;
    @(posedge core_clk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    {srst, flashErased, wakeInterrupt, stopInstr, waitInstr, avsRead, avsWrite} = 7'h40;
    {nvSecBits, avsAddress, avsWriteData, pat, rom, osc, cmd} = {2'h2, 42'h0};
    for (int i = 0; i < 8; i++)
    begin
      pat <= rows[i][4:2];
      rom <= rows[i][1];
      osc <= i[0];
      rstRun;
      chk(modeBits, rows[i][4:2]);
      chk(flashVisible, rows[i][0]);
      chk(flashInMap, rows[i][0]);
      chk(colpittsSel, i[0]);
      chk(debugActive, rows[i][4:2] == 3'h0);
    end
    $display("mode table done");
    nvSecBits <= 2'h0;
    pat <= 3'h5;
    rom <= 1;
    rstRun;
    chk({secured, debugBlocked, flashInMap}, 3'h6);
    cmd <= 1;
    repeat (6) @(posedge core_clk);
    chk(debugActive, 1);
    cmd <= 0;
    bus(1, 4'h0, 0);
    bus(0, 4'h0, 0);
    chk(rd, 5);
    bus(1, 4'h0, 7);
    bus(0, 4'h0, 0);
    chk(rd, 7);
    bus(0, 4'hf, 0);
    chk(rd, 0);
    $display("secured expanded done");
    pat <= 3'h4;
    rstRun;
    chk({debugBlocked, flashInMap}, 2'h3);
    bus(1, 4'h1, 0);
    repeat (3) @(posedge core_clk);
    chk({flashVisible, flashInMap}, 2'h2);
    bus(0, 4'h1, 0);
    chk(rd, 0);
    $display("secured single chip done");
    pat <= 3'h0;
    flashErased <= 1;
    rstRun;
    bus(0, 4'h2, 0);
    chk(rd[1:0], 2'h3);
    chk(secProgramOk, 1);
    bus(1, 4'h2, 2);
    repeat (2) @(posedge core_clk);
    chk(secured, 0);
    rstRun;
    chk(secured, 1);
    $display("unsecure done");
    lowPower(1, 2'h3);
    chk({oscEnable, coreClkEn, tickWdogEn}, 3'h0);
    wake;
    chk(oscEnable, 1);
    lowPower(1, 2'h2);
    chk({oscEnable, tickWdogEn, periphClkEn}, 3'h6);
    wake;
    lowPower(0, 2'h1);
    chk({cpuHalt, periphClkEn}, 2'h3);
    wake;
    chk(cpuHalt, 0);
    $display("low power done");
    results;
  end
endmodule // testbench
`default_nettype wire

/* rtl/mspc_config.v */
// mode capture, security and low-power control with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
`include "mspc_consts.vh"
module mspc_config #(
  parameter VERIFY_CYCLES = ((`MSPC_VERIFY_NS * 25) + 999) / 1000
) (
  input  wire        core_clk,
  input  wire        srst,
  input  wire        modeStrapHigh,
  input  wire        modeStrapMid,
  input  wire        modeStrapLow,
  input  wire        flashMapStrap,
  input  wire        oscillatorTypeStrap,
  input  wire [1:0]  nvSecBits,
  input  wire        debugActivateCmd,
  input  wire        flashErased,
  input  wire        wakeInterrupt,
  input  wire        stopInstr,
  input  wire        waitInstr,
  input  wire [3:0]  avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWriteData,
  output reg  [31:0] avsReadData,
  output reg         avsWaitRequest,
  output reg  [2:0]  modeBits,
  output reg         flashVisible,
  output reg         flashInMap,
  output reg         colpittsSel,
  output reg         debugActive,
  output reg         debugBlocked,
  output reg         secured,
  output reg         secProgramOk,
  output reg         oscEnable,
  output reg         coreClkEn,
  output reg         periphClkEn,
  output reg         tickWdogEn,
  output reg         cpuHalt
);
  //////////////////////////////////////////////////////////////////////////////
  wire [4:0] strapSync;
  wire       actSync;
  wire       wakeSync;
  mspc_sync2 #(.W(5)) uStraps (
    .core_clk (core_clk),
    .pinIn    ({modeStrapHigh, modeStrapMid, modeStrapLow, flashMapStrap,
                oscillatorTypeStrap}),
    .pinSync  (strapSync)
  );
  mspc_sync2 #(.W(2)) uCmd (
    .core_clk (core_clk),
    .pinIn    ({debugActivateCmd, wakeInterrupt}),
    .pinSync  ({actSync, wakeSync})
  );

  function fvDecode;
    input [2:0] m;
    input       pin;
    begin
      case (m)
        `MSPC_MODE_SSC: fvDecode = 1'b1;  // R5
        `MSPC_MODE_EMN: fvDecode = ~pin;  // R7
        `MSPC_MODE_STW: fvDecode = 1'b0;  // R8
        `MSPC_MODE_EMW: fvDecode = ~pin;  // R9
        `MSPC_MODE_NSC: fvDecode = 1'b1;  // R10
        `MSPC_MODE_PER: fvDecode = 1'b1;  // R12
        default:        fvDecode = pin;   // R11
      endcase
    end
  endfunction

  // allowed software changes: special modes may go anywhere except peripheral,
  // normal modes may only move between normal expanded and single chip
  function modeChangeOk;
    input [2:0] cur;
    input [2:0] nxt;
    begin
      if (nxt == `MSPC_MODE_PER)
        modeChangeOk = 1'b0;
      else if (~cur[2])
        modeChangeOk = 1'b1;
      else
        modeChangeOk = nxt[2];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // capture state: held in reset, straps latched on the first edge after release
  reg inReset_q;
  reg captured_q;
  wire capture = inReset_q & ~srst;
  always @(posedge core_clk)
  begin
    inReset_q <= srst;
  end

  localparam ST_IDLE   = 3'b001;
  localparam ST_VERIFY = 3'b010;
  localparam ST_DONE   = 3'b100;
  reg [2:0]  unsecSt_q;
  reg [15:0] verifyCnt_q;
  reg        swUnsec_q;
  reg        swFvClr_q;
  reg [1:0]  pwrMode_q;
  reg        stopped_q;
  reg        waiting_q;

  wire isSec  = (nvSecBits != `MSPC_SEC_UNSEC) & ~swUnsec_q;  // R14
  wire wrMode = avsWrite & ~avsWaitRequest & (avsAddress == `MSPC_ADDR_MODE);
  wire wrMisc = avsWrite & ~avsWaitRequest & (avsAddress == `MSPC_ADDR_MISC);
  wire wrSec  = avsWrite & ~avsWaitRequest & (avsAddress == `MSPC_ADDR_SEC);
  wire wrPwr  = avsWrite & ~avsWaitRequest & (avsAddress == `MSPC_ADDR_PWR);

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      modeBits     <= `MSPC_MODE_SSC;
      flashVisible <= 1'b0;
      colpittsSel  <= 1'b0;
      captured_q   <= 1'b0;
      debugActive  <= 1'b0;
      swUnsec_q    <= 1'b0;  // R19
      swFvClr_q    <= 1'b0;
      unsecSt_q    <= ST_IDLE;
      verifyCnt_q  <= 16'h0000;
    end
    else
    begin
      if (capture)
      begin
        modeBits     <= strapSync[4:2];                      // R1
        flashVisible <= fvDecode(strapSync[4:2], strapSync[1]);  // R2
        colpittsSel  <= strapSync[0];                        // R13
        captured_q   <= 1'b1;
        debugActive  <= (strapSync[4:2] == `MSPC_MODE_SSC);  // R5
      end
      else
      begin
        if (wrMode && modeChangeOk(modeBits, avsWriteData[2:0]))  // R4
          modeBits <= avsWriteData[2:0];
        if (wrMisc)
          swFvClr_q <= ~avsWriteData[0];
        if (actSync)
          debugActive <= 1'b1;  // R6
      end
      case (unsecSt_q)
        ST_IDLE:
        begin
          if (capture && isSec && flashErased && strapSync[4:2] == `MSPC_MODE_SSC)  // R17
          begin
            unsecSt_q   <= ST_VERIFY;  // R18
            verifyCnt_q <= 16'h0000;
          end
        end
        ST_VERIFY:
        begin
          if (!flashErased)
            unsecSt_q <= ST_IDLE;
          else if (verifyCnt_q == VERIFY_CYCLES[15:0] - 16'h0001)
            unsecSt_q <= ST_DONE;
          else
            verifyCnt_q <= verifyCnt_q + 16'h0001;
        end
        ST_DONE:
        begin
          if (wrSec && avsWriteData[1:0] == `MSPC_SEC_UNSEC)
            swUnsec_q <= 1'b1;  // R18
        end
        default: unsecSt_q <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // derived security and map outputs
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      secured      <= 1'b1;
      debugBlocked <= 1'b1;
      flashInMap   <= 1'b0;
      secProgramOk <= 1'b0;
    end
    else
    begin
      secured      <= isSec;
      debugBlocked <= isSec & (modeBits != `MSPC_MODE_SSC);  // R15 R16
      flashInMap   <= flashVisible & ~swFvClr_q & captured_q
                      & ~(isSec & modeBits[0]);             // R3 R16
      secProgramOk <= (unsecSt_q == ST_DONE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // low-power control
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      pwrMode_q   <= `MSPC_PWR_RUN;
      stopped_q   <= 1'b0;
      waiting_q   <= 1'b0;
      oscEnable   <= 1'b1;
      coreClkEn   <= 1'b1;
      periphClkEn <= 1'b1;
      tickWdogEn  <= 1'b1;
      cpuHalt     <= 1'b0;
    end
    else
    begin
      if (wrPwr)
        pwrMode_q <= avsWriteData[1:0];
      if (wakeSync)
      begin
        stopped_q <= 1'b0;  // R20
        waiting_q <= 1'b0;
      end
      else if (stopInstr && pwrMode_q[1])
        stopped_q <= 1'b1;
      else if (waitInstr)
        waiting_q <= 1'b1;  // R22
      oscEnable   <= ~(stopped_q & (pwrMode_q == `MSPC_PWR_STOP));  // R20 R21
      coreClkEn   <= ~stopped_q & ~waiting_q;
      periphClkEn <= ~stopped_q;  // R21 R22
      tickWdogEn  <= ~(stopped_q & (pwrMode_q == `MSPC_PWR_STOP));  // R21
      cpuHalt     <= stopped_q | waiting_q;  // R22
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle then answer
  reg [31:0] rdMux;
  always @*
  begin
    rdMux = 32'h00000000;
    case (avsAddress)
      `MSPC_ADDR_MODE: rdMux = {29'h0, modeBits};
      `MSPC_ADDR_MISC: rdMux = {31'h0, flashVisible & ~swFvClr_q};
      `MSPC_ADDR_SEC:  rdMux = {30'h0, isSec, secProgramOk};
      `MSPC_ADDR_PWR:  rdMux = {30'h0, pwrMode_q};
      `MSPC_ADDR_STAT: rdMux = {27'h0, colpittsSel, debugActive, debugBlocked,
                                stopped_q, waiting_q};
      default:         rdMux = 32'h00000000;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (srst)
    begin
      avsWaitRequest <= 1'b1;
      avsReadData    <= 32'h00000000;
    end
    else
    begin
      if ((avsRead | avsWrite) & avsWaitRequest)
        avsWaitRequest <= 1'b0;
      else
        avsWaitRequest <= 1'b1;
      if (avsRead & avsWaitRequest)
        avsReadData <= rdMux;
    end
  end
endmodule // mspc_config
`default_nettype wire

/* rtl/mspc_consts.vh */
// constants and operating summary for the mode, security and power configuration block
// Summary of operation
// (R1) mode straps captured into mode bits as reset releases; bits report mode
// (R2) flash-map strap captured into flash visible bit at reset release
// (R3) flash visible bit 1 puts internal flash in map, else absent
// (R4) software may write only a restricted set of mode changes
// (R5) pattern 000 special single chip; debug active now; flash visible forced 1
// (R6) other modes debug permitted but inactive until host activation command
// (R7) pattern 001 emulation narrow; flash visible is inverse of flash-map strap
// (R8) pattern 010 special test wide; flash visible cleared
// (R9) pattern 011 emulation wide; flash visible is inverse of flash-map strap
// (R10) pattern 100 normal single chip; flash visible forced 1
// (R11) patterns 101 and 111 normal expanded; flash visible equals strap
// (R12) board must not strap 110 peripheral mode; flash visible reads 1
// (R13) oscillator strap 1 selects Colpitts, 0 Pierce or external clock
// (R14) security held in nonvolatile bits, persists over reset and power
// (R15) secured normal single chip behaves unsecured except debug blocked
// (R16) secured expanded mode disables internal flash and blocks debug
// (R17) unsecuring requires flash erase first by any of three means
// (R18) after erase, special single chip runs erase verify, then reprogram allowed
// (R19) any reset before reprogramming unsecured returns device to secured
// (R20) full stop halts all clocks and oscillator; wake on reset or interrupt
// (R21) pseudo stop keeps oscillator, tick and watchdog may run, rest off
// (R22) wait stops execution, buses static, peripherals active, may gate clocks
// (R23) board holds straps stable through reset and its release
`ifndef MSPC_CONSTS_VH
`define MSPC_CONSTS_VH
`define MSPC_MODE_SSC   3'h0
`define MSPC_MODE_EMN   3'h1
`define MSPC_MODE_STW   3'h2
`define MSPC_MODE_EMW   3'h3
`define MSPC_MODE_NSC   3'h4
`define MSPC_MODE_NXN   3'h5
`define MSPC_MODE_PER   3'h6
`define MSPC_MODE_NXW   3'h7
`define MSPC_ADDR_MODE  4'h0
`define MSPC_ADDR_MISC  4'h1
`define MSPC_ADDR_SEC   4'h2
`define MSPC_ADDR_PWR   4'h3
`define MSPC_ADDR_STAT  4'h4
`define MSPC_SEC_UNSEC  2'h2
`define MSPC_SEC_RESET  2'h0
`define MSPC_PWR_RUN    2'h0
`define MSPC_PWR_WAIT   2'h1
`define MSPC_PWR_PSTOP  2'h2
`define MSPC_PWR_STOP   2'h3
`define MSPC_VERIFY_NS  2000
`endif

/* rtl/mspc_sync2.v */
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module mspc_sync2 #(
  parameter W = 1
) (
  input  wire         core_clk,
  input  wire [W-1:0] pinIn,
  output reg  [W-1:0] pinSync
);
  reg [W-1:0] meta_q;
  always @(posedge core_clk)
  begin
    meta_q  <= pinIn;
    pinSync <= meta_q;
  end
endmodule // mspc_sync2
`default_nettype wire
